/* File: hdl/srob_status_bank.sv */
/*
 * srob_status_bank: paired nonvolatile/volatile status register one with
 * pin-based write lock and sticky program and erase failure flags.
 * assumes: a host transaction decoder turns serial commands into one-cycle
 * strobes synchronous to sys_clk; rst_n stands for power-up.
 */
//
// Functional notes
// - resets reload volatile bits from nonvolatile copy
// - nonvolatile write updates volatile copy too
// - volatile write leaves nonvolatile copy untouched
// - otp bits program once; read-only bits ignore writes
// - bit 7 selects pin lock, default off
// - single lane, lock set, pin low: ignore
// - protect pin high permits register writes unless busy
// - program failure sets bit 6
// - protected program attempt sets bit 6
// - bit 6 sticks until clear or reset
// - no standby while bit 6 set
// - erase failure sets bit 5
// - protected erase attempt sets bit 5
// - bit 5 sticks until clear or reset
// - no standby while bit 5 set
// - failure flags keep busy bit 0 set
//
`timescale 1ns/1ns
module srob_status_bank (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        hw_reset,
  input  wire logic        soft_reset,
  // pins and mode
  input  wire logic        wp_level,
  input  wire logic        single_spi,
  input  wire logic        chip_select_active,
  // register transactions
  input  wire logic        reg_write,
  input  wire logic        write_nonvolatile,
  input  wire logic [7:0]  write_data,
  input  wire logic        reg_read,
  input  wire logic        read_nonvolatile,
  input  wire logic        clear_fail_flags,
  // embedded operation events
  input  wire logic        op_start_program,
  input  wire logic        op_start_erase,
  input  wire logic        op_target_protected,
  input  wire logic        op_done,
  input  wire logic        op_failed,
  // register readout
  output logic [7:0]       read_data,
  output logic             write_done,
  output logic             write_ignored,
  // status outputs
  output logic             pin_write_lock_select,
  output logic             program_fail_flag,
  output logic             erase_fail_flag,
  output logic             ready_busy_flag,
  output logic             standby,
  output logic             config_write_permit
);

  // ***********************************************************************
  // state
  // ***********************************************************************
  typedef struct packed {
    logic [7:0] nonvolatile;
    logic [7:0] volatile_bits;
    logic [7:0] otp_done;
    logic [7:0] read_data;
    logic       write_done;
    logic       write_ignored;
  } srob_bank_t;

  localparam srob_bank_t BANK_RESET = '{
    nonvolatile:   srob_pkg::FACTORY_DEFAULT,
    volatile_bits: srob_pkg::FACTORY_DEFAULT,
    otp_done:      srob_pkg::ZERO_BYTE,
    read_data:     srob_pkg::ZERO_BYTE,
    write_done:    1'b0,
    write_ignored: 1'b0
  };

  srob_bank_t  bank;
  srob_bank_t  next_bank;
  logic        flag_reset;
  logic        write_blocked;
  logic [7:0]  nv_merged;

  srob_ctl_if ctl ();

  // ***********************************************************************
  // helpers
  // ***********************************************************************
  // merge a write into a stored byte honouring the access class of each bit
  function automatic logic [7:0] apply_write(
    input logic [7:0] old_value,
    input logic [7:0] data,
    input logic [7:0] rw_mask,
    input logic [7:0] otp_mask,
    input logic [7:0] otp_used
  );
    logic [7:0] otp_open;
    otp_open    = otp_mask & ~otp_used;
    apply_write = (old_value & ~(rw_mask | otp_open)) |
                  (data & (rw_mask | otp_open));
  endfunction

  // live view of the volatile register; bits 4:1 are not modelled, read zero
  function automatic logic [7:0] compose_status(
    input logic [7:0] vol,
    input logic       prg,
    input logic       ers,
    input logic       busy
  );
    logic [7:0] value;
    value                         = vol & srob_pkg::VOL_RW_MASK;
    value[srob_pkg::PRG_FAIL_BIT] = prg;
    value[srob_pkg::ERS_FAIL_BIT] = ers;
    value[srob_pkg::BUSY_BIT]     = busy;
    compose_status                = value;
  endfunction

  // ***********************************************************************
  // submodules
  // ***********************************************************************
  assign ctl.lock_sel   = bank.volatile_bits[srob_pkg::LOCK_SEL_BIT];
  assign ctl.single_spi = single_spi;
  assign ctl.wp_level   = wp_level;
  assign flag_reset     = hw_reset || soft_reset;

  srob_write_guard i_srob_write_guard (
    .ctl                 (ctl.guard)
  );

  srob_flag_tracker i_srob_flag_tracker (
    .sys_clk             (sys_clk),
    .rst_n               (rst_n),
    .flag_reset          (flag_reset),
    .op_start_program    (op_start_program),
    .op_start_erase      (op_start_erase),
    .op_target_protected (op_target_protected),
    .op_done             (op_done),
    .op_failed           (op_failed),
    .clear_fail_flags    (clear_fail_flags),
    .ctl                 (ctl.tracker)
  );

  // a write is dropped when locked or while the device reports busy
  assign write_blocked = !ctl.write_unlocked || ctl.ready_busy;

  // nonvolatile image after a write, shared by both copies
  assign nv_merged = apply_write(bank.nonvolatile, write_data, srob_pkg::NV_RW_MASK,
                                 srob_pkg::OTP_MASK, bank.otp_done);

  // ***********************************************************************
  // next state
  // ***********************************************************************
  always_comb begin
    next_bank               = bank;
    next_bank.write_done    = 1'b0;
    next_bank.write_ignored = 1'b0;
    if (flag_reset) begin
      // reset reload wins over a write arriving in the same cycle
      next_bank.volatile_bits = bank.nonvolatile;
    end else if (reg_write) begin
      if (write_blocked) begin
        next_bank.write_ignored = 1'b1;
      end else if (write_nonvolatile) begin
        next_bank.nonvolatile   = nv_merged;
        next_bank.volatile_bits = (bank.volatile_bits & ~srob_pkg::NV_RW_MASK) |
                                  (nv_merged & srob_pkg::NV_RW_MASK);
        next_bank.otp_done      = bank.otp_done | (write_data & srob_pkg::OTP_MASK);
        next_bank.write_done    = 1'b1;
      end else begin
        // nonvolatile copy keeps its contents on a volatile-only write
        next_bank.volatile_bits = apply_write(bank.volatile_bits, write_data,
                                              srob_pkg::VOL_RW_MASK,
                                              srob_pkg::ZERO_BYTE,
                                              srob_pkg::ZERO_BYTE);
        next_bank.write_done    = 1'b1;
      end
    end
    // reads capture a snapshot; values taken during a reset are not meaningful
    if (reg_read) begin
      if (read_nonvolatile) begin
        next_bank.read_data = bank.nonvolatile & srob_pkg::NV_RW_MASK;
      end else begin
        next_bank.read_data = compose_status(bank.volatile_bits, ctl.prg_fail,
                                             ctl.ers_fail, ctl.ready_busy);
      end
    end
  end

  // ***********************************************************************
  // state register
  // ***********************************************************************
  // power-up loads factory defaults into both copies
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      bank <= BANK_RESET;
    end else begin
      bank <= next_bank;
    end
  end

  // ***********************************************************************
  // outputs
  // ***********************************************************************
  assign read_data             = bank.read_data;
  assign write_done            = bank.write_done;
  assign write_ignored         = bank.write_ignored;
  assign pin_write_lock_select = bank.volatile_bits[srob_pkg::LOCK_SEL_BIT];
  assign program_fail_flag     = ctl.prg_fail;
  assign erase_fail_flag       = ctl.ers_fail;
  assign ready_busy_flag       = ctl.ready_busy;
  // standby only once deselected and every flag has been cleared
  assign standby               = !chip_select_active && !ctl.ready_busy;
  assign config_write_permit   = ctl.write_unlocked;   // gates config registers one to four

endmodule // srob_status_bank

/* File: hdl/srob_pkg.sv */
/*
 * srob_pkg: constants and types shared by the status register one bank.
 * assumes: included first in compile order; nothing is imported, every use is scoped.
 */
package srob_pkg;

  // ***********************************************************************
  // register geometry
  // ***********************************************************************
  localparam int          REG_W         = 8;
  localparam int          LOCK_SEL_BIT  = 7;
  localparam int          PRG_FAIL_BIT  = 6;
  localparam int          ERS_FAIL_BIT  = 5;
  localparam int          BUSY_BIT      = 0;

  // ***********************************************************************
  // reset values and access classes
  // ***********************************************************************
  localparam logic [7:0]  FACTORY_DEFAULT = 8'h00;  // lock select off
  localparam logic [7:0]  NV_RW_MASK      = 8'h80;  // nonvolatile bits accepting writes
  localparam logic [7:0]  VOL_RW_MASK     = 8'h80;  // volatile bits accepting writes
  localparam logic [7:0]  OTP_MASK        = 8'h00;  // one-time programmable bits
  localparam logic [7:0]  ZERO_BYTE       = 8'h00;

  // ***********************************************************************
  // embedded operation states
  // ***********************************************************************
  typedef enum logic [1:0] {
    srob_op_idle,
    srob_op_program,
    srob_op_erase
  } srob_op_t;

endpackage

/* File: hdl/srob_ctl_if.sv */
/*
 * srob_ctl_if: lock and failure-flag signals passed among the bank's modules.
 * assumes: instantiated inside the bank top only; no clocking of its own.
 */
`timescale 1ns/1ns
interface srob_ctl_if;
  logic lock_sel;
  logic single_spi;
  logic wp_level;
  logic write_unlocked;
  logic prg_fail;
  logic ers_fail;
  logic ready_busy;
  logic op_active;

  modport top (output lock_sel, single_spi, wp_level,
               input  write_unlocked, prg_fail, ers_fail, ready_busy, op_active);
  modport guard (input lock_sel, single_spi, wp_level, output write_unlocked);
  modport tracker (output prg_fail, ers_fail, ready_busy, op_active);
endinterface

/* File: hdl/srob_write_guard.sv */
/*
 * srob_write_guard: decides whether status and configuration writes may proceed.
 * assumes: pin levels arrive synchronous to sys_clk; purely combinational.
 */
`timescale 1ns/1ns
module srob_write_guard (
  // control signals
  srob_ctl_if.guard ctl
);

  // ***********************************************************************
  // lock decision
  // ***********************************************************************
  // a high protect pin always unlocks; the lock only bites in single-lane mode
  always_comb begin
    ctl.write_unlocked = 1'b1;
    if (ctl.wp_level) begin
      ctl.write_unlocked = 1'b1;
    end else if (ctl.single_spi && ctl.lock_sel) begin
      ctl.write_unlocked = 1'b0;
    end
  end

endmodule // srob_write_guard

/* File: hdl/srob_flag_tracker.sv */
/*
 * srob_flag_tracker: embedded program/erase tracking and sticky failure flags.
 * assumes: operation events are one-cycle pulses synchronous to sys_clk.
 */
`timescale 1ns/1ns
module srob_flag_tracker (
  // clock and reset
  input  wire logic  sys_clk,
  input  wire logic  rst_n,
  input  wire logic  flag_reset,
  // operation events
  input  wire logic  op_start_program,
  input  wire logic  op_start_erase,
  input  wire logic  op_target_protected,
  input  wire logic  op_done,
  input  wire logic  op_failed,
  input  wire logic  clear_fail_flags,
  // shared flags
  srob_ctl_if.tracker ctl
);

  typedef struct packed {
    srob_pkg::srob_op_t op;
    logic               prg;
    logic               ers;
  } srob_track_t;

  localparam srob_track_t TRACK_RESET = '{srob_pkg::srob_op_idle, 1'b0, 1'b0};

  srob_track_t state;
  srob_track_t next_state;
  logic        busy;

  // ***********************************************************************
  // next state
  // ***********************************************************************
  // clear comes first so a failure in the same cycle still lands
  always_comb begin
    next_state = state;
    busy = (state.op != srob_pkg::srob_op_idle) || state.prg || state.ers;
    if (clear_fail_flags) begin
      next_state.prg = 1'b0;
      next_state.ers = 1'b0;
    end
    case (state.op)
      srob_pkg::srob_op_idle: begin
        // new operations refused while any flag holds the device busy
        if (op_start_program && !busy) begin
          if (op_target_protected) begin
            next_state.prg = 1'b1;
          end else begin
            next_state.op = srob_pkg::srob_op_program;
          end
        end else if (op_start_erase && !busy) begin
          if (op_target_protected) begin
            next_state.ers = 1'b1;
          end else begin
            next_state.op = srob_pkg::srob_op_erase;
          end
        end
      end
      srob_pkg::srob_op_program: begin
        if (op_done) begin
          next_state.op = srob_pkg::srob_op_idle;
          if (op_failed) begin
            next_state.prg = 1'b1;
          end
        end
      end
      srob_pkg::srob_op_erase: begin
        if (op_done) begin
          next_state.op = srob_pkg::srob_op_idle;
          if (op_failed) begin
            next_state.ers = 1'b1;
          end
        end
      end
      default: begin
        next_state.op = srob_pkg::srob_op_idle;
      end
    endcase
    if (flag_reset) begin
      next_state = TRACK_RESET;
    end
  end

  // ***********************************************************************
  // state register
  // ***********************************************************************
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= TRACK_RESET;
    end else begin
      state <= next_state;
    end
  end

  // busy stays up while a flag is set, so standby waits on the clear
  assign ctl.prg_fail   = state.prg;
  assign ctl.ers_fail   = state.ers;
  assign ctl.ready_busy = busy;
  assign ctl.op_active  = (state.op != srob_pkg::srob_op_idle);

endmodule // srob_flag_tracker

/* File: tb/srob_status_bank_assertions.sv */
/* srob_status_bank_assertions: port checks for the status register one bank.
   assumes: bound to srob_status_bank from the bench top file. */
`timescale 1ns/1ns
module srob_status_bank_assertions (
  // clock and resets
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       hw_reset,
  input wire logic       soft_reset,
  // pins and requests
  input wire logic       wp_level,
  input wire logic       single_spi,
  input wire logic       reg_write,
  input wire logic [7:0] write_data,
  input wire logic       clear_fail_flags,
  input wire logic       op_start_program,
  input wire logic       op_start_erase,
  input wire logic       op_target_protected,
  input wire logic       op_done,
  // answers
  input wire logic       write_done,
  input wire logic       write_ignored,
  input wire logic       pin_write_lock_select,
  input wire logic       program_fail_flag,
  input wire logic       erase_fail_flag,
  input wire logic       ready_busy_flag,
  input wire logic       standby,
  input wire logic       config_write_permit
);
  // ***************************************************************
  // helpers and sequences
  // ***************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // reset pulses drop a write, so they stay out of every antecedent but p_busy and p_standby
  wire quiet = !hw_reset && !soft_reset;
  wire fail  = program_fail_flag || erase_fail_flag;
  wire idle  = quiet && !ready_busy_flag;
  sequence s_take; reg_write && idle; endsequence
  sequence s_locked; single_spi && pin_write_lock_select && !wp_level; endsequence
  // ***************************************************************
  // properties
  // ***************************************************************
  property p_wr_ok;
    s_take ##0 config_write_permit |=>
      write_done && pin_write_lock_select == $past(write_data[7]);
  endproperty
  property p_locked; s_take ##0 s_locked |=> write_ignored && pin_write_lock_select; endproperty
  property p_wp_high; s_take ##0 wp_level |=> write_done; endproperty
  property p_prg_stick; program_fail_flag && quiet && !clear_fail_flags |=> program_fail_flag;
  endproperty
  property p_ers_stick; erase_fail_flag && quiet && !clear_fail_flags |=> erase_fail_flag;
  endproperty
  property p_busy; fail |-> ready_busy_flag; endproperty
  property p_standby; fail |-> !standby; endproperty
  property p_prot_prg;
    op_start_program && op_target_protected && idle |=> program_fail_flag && ready_busy_flag;
  endproperty
  property p_prot_ers;
    op_start_erase && !op_start_program && op_target_protected && idle |=> erase_fail_flag;
  endproperty
  property p_clear;
    clear_fail_flags && quiet && !op_done && !op_start_program && !op_start_erase |=> !fail;
  endproperty
  a_wr_ok: assert property (p_wr_ok) else $error("open write not applied");
  a_locked: assert property (p_locked) else $error("locked write applied");
  a_wp_high: assert property (p_wp_high) else $error("write refused with pin high");
  a_prg_stick: assert property (p_prg_stick) else $error("program flag dropped");
  a_ers_stick: assert property (p_ers_stick) else $error("erase flag dropped");
  a_busy: assert property (p_busy) else $error("ready with flag set");
  a_standby: assert property (p_standby) else $error("standby with flag set");
  a_prot_prg: assert property (p_prot_prg) else $error("protected program not flagged");
  a_prot_ers: assert property (p_prot_ers) else $error("protected erase not flagged");
  a_clear: assert property (p_clear) else $error("flags survive clear");
endmodule // srob_status_bank_assertions

/* File: tb/srob_host_model.sv */
/* srob_host_model: host controller issuing status register transactions.
   assumes: device registers its answer on the taking edge; host reads it just after. */
`timescale 1ns/1ns
module srob_host_model (
  // clock
  input  wire logic       sys_clk,
  // device answers
  input  wire logic       write_done,
  input  wire logic       write_ignored,
  input  wire logic [7:0] read_data,
  // register requests
  output logic            reg_write,
  output logic            write_nonvolatile,
  output logic [7:0]      write_data,
  output logic            reg_read,
  output logic            read_nonvolatile,
  output logic            clear_fail_flags
);
  // ***************************************************************
  // transactions
  // ***************************************************************
  // idle levels from time zero
  initial begin
    {reg_write, write_nonvolatile, reg_read, read_nonvolatile, clear_fail_flags} = 5'h00;
    write_data = 8'h00;
  end
  // one byte; bus inverted after so no stale byte can pass for data
  task automatic wr(input logic nv, input logic [7:0] d, output logic [1:0] ans);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    write_nonvolatile <= nv;
    write_data <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    write_data <= ~d;
    #1 ans = {write_done, write_ignored};
  endtask
  // only issued outside reset pulses, so no invalid value is kept
  task automatic rd(input logic nv, output logic [7:0] q);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    read_nonvolatile <= nv;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 q = read_data;
  endtask
  // flag clear transaction
  task automatic clr;
    @(posedge sys_clk);
    clear_fail_flags <= 1'b1;
    @(posedge sys_clk);
    clear_fail_flags <= 1'b0;
    #1;
  endtask
endmodule // srob_host_model

/* File: tb/srob_status_bank_tb.sv */
/* srob_status_bank_tb: self-checking bench for the status register one bank.
   assumes: host model issues register requests; bench drives pins and events. */
`timescale 1ns/1ns
module srob_status_bank_tb;
  typedef struct packed {
    logic spi; logic wp; logic nv; logic [7:0] d;
    logic [1:0] ans; logic [7:0] vol; logic [7:0] nvc;
  } srob_row_t;
  logic       sys_clk = 1'b0, rst_n = 1'b0, hw_reset = 1'b0, soft_reset = 1'b0;
  logic       wp_level = 1'b0, single_spi = 1'b1, chip_select_active = 1'b0;
  logic [4:0] op = 5'h00;
  logic       reg_write, write_nonvolatile, reg_read, read_nonvolatile, clear_fail_flags;
  logic       write_done, write_ignored, pin_write_lock_select, program_fail_flag;
  logic       erase_fail_flag, ready_busy_flag, standby, config_write_permit;
  logic [7:0] write_data, read_data, q;
  logic [1:0] a;
  int         error_cnt = 0, comparisons = 0, cycles = 0;
  // state carries from row to row: pins, write, then both copies read back
  srob_row_t  rows [6] = '{
    '{1'b1, 1'b0, 1'b0, 8'hff, 2'b10, 8'h80, 8'h00},
    '{1'b1, 1'b0, 1'b1, 8'h00, 2'b01, 8'h80, 8'h00},
    '{1'b1, 1'b1, 1'b1, 8'h80, 2'b10, 8'h80, 8'h80},
    '{1'b0, 1'b0, 1'b0, 8'h00, 2'b10, 8'h00, 8'h80},
    '{1'b1, 1'b0, 1'b0, 8'hff, 2'b10, 8'h80, 8'h80},
    '{1'b1, 1'b0, 1'b0, 8'h00, 2'b01, 8'h80, 8'h80}};
  srob_status_bank i_srob_status_bank (.sys_clk, .rst_n, .hw_reset, .soft_reset,
    .wp_level, .single_spi, .chip_select_active, .reg_write, .write_nonvolatile,
    .write_data, .reg_read, .read_nonvolatile, .clear_fail_flags,
    .op_start_program(op[4]), .op_start_erase(op[3]), .op_target_protected(op[2]),
    .op_done(op[1]), .op_failed(op[0]), .read_data, .write_done, .write_ignored,
    .pin_write_lock_select, .program_fail_flag, .erase_fail_flag, .ready_busy_flag,
    .standby, .config_write_permit);
  srob_host_model i_srob_host_model (.sys_clk, .write_done, .write_ignored, .read_data,
    .reg_write, .write_nonvolatile, .write_data, .reg_read, .read_nonvolatile,
    .clear_fail_flags);
  // ***************************************************************
  // clock, watchdog and helpers
  // ***************************************************************
  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  // the sequence needs under two hundred cycles; a hang ends here
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // op bits: start program, start erase, protected, done, failed
  task automatic op_pulse(input logic [4:0] v);
    @(posedge sys_clk);
    op <= v;
    @(posedge sys_clk);
    op <= 5'h00;
    #1;
  endtask
  task automatic rpulse(input logic [1:0] v);
    @(posedge sys_clk);
    {hw_reset, soft_reset} <= v;
    @(posedge sys_clk);
    {hw_reset, soft_reset} <= 2'b00;
  endtask
  task automatic power_up;
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
  endtask
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    power_up();
    foreach (rows[i]) begin
      @(posedge sys_clk);
      single_spi <= rows[i].spi;
      wp_level <= rows[i].wp;
      i_srob_host_model.wr(rows[i].nv, rows[i].d, a);
      chk({6'h00, a}, {6'h00, rows[i].ans}, "write answer");
      i_srob_host_model.rd(1'b0, q);
      chk(q, rows[i].vol, "volatile copy");
      i_srob_host_model.rd(1'b1, q);
      chk(q, rows[i].nvc, "nonvolatile copy");
    end
    // last row leaves single lane, lock set and pin low
    chk({7'h00, config_write_permit}, 8'h00, "permit while locked");
    $display("test rows done");
    @(posedge sys_clk);
    wp_level <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      i_srob_host_model.wr(1'b0, 8'h00, a);
      rpulse(k ? 2'b01 : 2'b10);
      i_srob_host_model.rd(1'b0, q);
      chk(q, 8'h80, "reload");
    end
    $display("test reload done");
    power_up();
    // pin low so the permit below depends on the factory lock value alone
    wp_level <= 1'b0;
    i_srob_host_model.rd(1'b1, q);
    chk(q, 8'h00, "factory default");
    chk({7'h00, config_write_permit}, 8'h01, "permit after power up");
    $display("test power up done");
    for (int k = 0; k < 2; k++) begin
      op_pulse(k ? 5'b01000 : 5'b10000);
      op_pulse(5'b00011);
      i_srob_host_model.wr(1'b1, 8'h80, a);
      chk({6'h00, a}, 8'h01, "write while failed");
      repeat (4) @(posedge sys_clk);
      i_srob_host_model.rd(1'b0, q);
      chk(q, k ? 8'h21 : 8'h41, "failed view");
      chk({7'h00, standby}, 8'h00, "standby with flag");
      i_srob_host_model.clr();
      op_pulse(k ? 5'b01000 : 5'b10000);
      op_pulse(5'b00010);
      i_srob_host_model.rd(1'b0, q);
      chk(q, 8'h00, "cleared then passed");
      chk({7'h00, standby}, 8'h01, "standby back");
      @(posedge sys_clk);
      chip_select_active <= 1'b1;
      @(posedge sys_clk);
      #1 chk({7'h00, standby}, 8'h00, "standby while selected");
      @(posedge sys_clk);
      chip_select_active <= 1'b0;
      op_pulse(k ? 5'b01100 : 5'b10100);
      i_srob_host_model.rd(1'b0, q);
      chk(q, k ? 8'h21 : 8'h41, "protected target");
      rpulse(k ? 2'b01 : 2'b10);
      i_srob_host_model.rd(1'b0, q);
      chk(q, 8'h00, "reset clears flags");
    end
    $display("test flags done");
    end_of_test();
  end
endmodule // srob_status_bank_tb

bind srob_status_bank srob_status_bank_assertions i_srob_status_bank_assertions (
  .sys_clk, .rst_n, .hw_reset, .soft_reset, .wp_level, .single_spi, .reg_write,
  .write_data, .clear_fail_flags, .op_start_program, .op_start_erase, .op_target_protected,
  .op_done, .write_done, .write_ignored, .pin_write_lock_select, .program_fail_flag,
  .erase_fail_flag, .ready_busy_flag, .standby, .config_write_permit);
